//--- src/vim_pkg.sv
// constants and types for the vectored interrupt and micro dma block
// ============================================================
// Summary of operation
// - highest priority pending channel presented first
// - source select bit picks converter or timer2
// - priority only among simultaneously pending requests
// - parameter block at FF00H plus vector
// - count, destination, source, mode byte layout
// - mode bits choose address update and length
// - address step equals transfer length
// - two byte copies src then src plus one
// - write back, decrement count, zero enters handler
// - dma leaves processor registers untouched
// - full sixteen bit source and destination
// - non final dma service takes 46 states; the code pads 27 cycles after the count write instead
// - fourteen channels with latch, enables only for channels 0 to 10
// - latch clears on reset, accept, clear write
// - status reads return request latches
// - status bit order per channel
// - interrupt enables written one, reset zero
// - dma enable selects dma, resets zero
// - enable register bit layouts
// - ext0 level mode bypasses latch, mode change clears
// - converter request cleared only by reset, result read, accept or source change
// - receive request cleared only by reset, read or accept
// - maskable need global enable, nmi always accepted
// - normal entry pushes pc and af, 20 states
package vim_pkg;
    localparam int NCH = 14;
    localparam logic [15:0] ADDR_LOW_STATUS = 16'hFFC2;
    localparam logic [15:0] ADDR_HIGH_STATUS = 16'hFFC3;
    localparam logic [15:0] ADDR_IRQ_EN = 16'hFFE6;
    localparam logic [15:0] ADDR_IRQ_DMA_EN = 16'hFFE7;
    localparam logic [15:0] ADDR_DMA_EN = 16'hFFE8;
    localparam logic [15:0] PARAM_BASE = 16'hFF00;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam int SRC_SEL_BIT = 3;
    localparam logic [7:0] VEC_FIRST = 8'h28;
    localparam logic [7:0] VEC_STEP = 8'h08;
    localparam logic [7:0] VEC_SWI = 8'h10;
    localparam logic [7:0] VEC_NMI = 8'h18;
    localparam logic [7:0] VEC_WD = 8'h20;
    localparam int DMA_STATES = 46;
    localparam int ENTRY_STATES = 20;
    // channel index: 0 ext0 ... 13 transmit, index order is priority order
    localparam int CH_EXT0 = 0;
    localparam int CH_T2AD = 3;
    localparam int CH_RX = 12;
    localparam logic [1:0] UPD_FIX = 2'b00;
    localparam logic [1:0] UPD_DST_INC = 2'b01;
    localparam logic [1:0] UPD_SRC_INC = 2'b10;
    localparam logic [1:0] UPD_SRC_DEC = 2'b11;
    localparam int MODE_LEN_BIT = 2;
    typedef enum logic [4:0] {
        S_IDLE = 5'b00000, S_ENTRY = 5'b00001, S_RD_PAR = 5'b00011,
        S_RD_SRC = 5'b00010, S_WR_DST = 5'b00110, S_WR_PAR = 5'b00111,
        S_RD_CNT = 5'b00101, S_WR_CNT = 5'b00100, S_PAD = 5'b01100
    } svc_state_t;
endpackage : vim_pkg

//--- src/vectored_irq_and_micro_dma.sv
// vectored interrupt controller with micro dma sequencer and apb registers
//
// Decided for this implementation: the APB register port.
`timescale 1ns/10ps
module vectored_irq_and_micro_dma #(
    parameter int NCH = vim_pkg::NCH
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [15:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    // raw request pins, indexed in priority order
    input wire logic [NCH-1:0] req_in,
    input wire logic converter_done_request_in,
    input wire logic ext0_level_mode_in,
    input wire logic converter_result_read_in,
    input wire logic receive_buffer_read_in,
    input wire logic software_trap_in,
    input wire logic nmi_in,
    input wire logic watchdog_request_in,
    input wire logic global_irq_enable_in,
    output logic irq_out,
    output logic [7:0] vector_out,
    input wire logic ack_in,
    output logic entry_busy_out,
    output logic clear_global_enable_out,
    // memory master for parameter fetch and data copy
    output logic mem_req_out,
    output logic mem_we_out,
    output logic [15:0] mem_addr_out,
    output logic [7:0] mem_wdata_out,
    input wire logic [7:0] mem_rdata_in,
    input wire logic mem_ack_in
);
    // ============================================================
    // input synchronisers
    logic [NCH-1:0] req_s1_r, req_s2_r, req_prev_r;
    logic [2:0] nm_s1_r, nm_s2_r, nm_prev_r;
    logic ad_s1_r, ad_s2_r, ad_prev_r, lvl_s1_r, lvl_s2_r, lvl_prev_r;
    logic [NCH-1:0] raw;
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            {req_s1_r, req_s2_r, req_prev_r} <= '0;
            {nm_s1_r, nm_s2_r, nm_prev_r} <= '0;
            {ad_s1_r, ad_s2_r, ad_prev_r, lvl_s1_r, lvl_s2_r, lvl_prev_r} <= '0;
        end else begin
            req_s1_r <= req_in;
            req_s2_r <= req_s1_r;
            req_prev_r <= raw;
            nm_s1_r <= {watchdog_request_in, nmi_in, software_trap_in};
            nm_s2_r <= nm_s1_r;
            nm_prev_r <= nm_s2_r;
            ad_s1_r <= converter_done_request_in;
            ad_s2_r <= ad_s1_r;
            ad_prev_r <= ad_s2_r;
            lvl_s1_r <= ext0_level_mode_in;
            lvl_s2_r <= lvl_s1_r;
            lvl_prev_r <= lvl_s2_r;
        end
    end

    // ============================================================
    // registers
    logic [7:0] irq_en_r, irq_dma_en_r, dma_en_r;
    logic [NCH-1:0] irq_en, dma_en, latch_r, pend;
    logic [2:0] nm_latch_r;
    logic wr_acc, src_sel;
    assign wr_acc = psel_in && penable_in && pwrite_in && pready_out;
    assign src_sel = irq_dma_en_r[vim_pkg::SRC_SEL_BIT];
    // flag layout, irq enables at FFE6H and FFE7H bits 0 to 2
    assign irq_en = NCH'({irq_en_r[0], irq_en_r[1], irq_en_r[2], irq_en_r[3], irq_en_r[4],
                     irq_en_r[5], irq_en_r[6], irq_en_r[7], irq_dma_en_r[0],
                     irq_dma_en_r[1], irq_dma_en_r[2]});
    assign dma_en = NCH'({dma_en_r[0], dma_en_r[1], dma_en_r[2], dma_en_r[3], dma_en_r[4],
                     dma_en_r[5], dma_en_r[6], dma_en_r[7], irq_dma_en_r[4],
                     irq_dma_en_r[5], irq_dma_en_r[6]});
    always_comb begin
        raw = req_s2_r;
        raw[vim_pkg::CH_T2AD] = src_sel ? ad_s2_r : req_s2_r[vim_pkg::CH_T2AD];
    end
    // irq enables reset to zero, dma enables too
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            irq_en_r <= vim_pkg::REG_RESET;
            irq_dma_en_r <= vim_pkg::REG_RESET;
            dma_en_r <= vim_pkg::REG_RESET;
        end else if (wr_acc) begin
            if (paddr_in == vim_pkg::ADDR_IRQ_EN) begin
                irq_en_r <= pwdata_in[7:0];
            end else if (paddr_in == vim_pkg::ADDR_IRQ_DMA_EN) begin
                // bit 7 always reads zero
                irq_dma_en_r <= {1'b0, pwdata_in[6:0]};
            end else if (paddr_in == vim_pkg::ADDR_DMA_EN) begin
                dma_en_r <= pwdata_in[7:0];
            end
        end
    end

    // ============================================================
    // request latches and priority
    logic [NCH-1:0] acc_clr, sw_clr;
    logic [3:0] win_idx, sel_idx_r;
    logic win_any, sel_nm_r, sel_dma_r, src_sel_prev_r;
    logic [7:0] sel_vec_r;
    logic [7:0] clr_code;
    logic [3:0] clr_idx;
    assign clr_code = pwdata_in[7:0] - (vim_pkg::VEC_FIRST >> 3);
    assign clr_idx = clr_code[3:0];
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            src_sel_prev_r <= 1'b0;
        end else begin
            src_sel_prev_r <= src_sel;
        end
    end
    genvar g;
    generate
        for (g = 0; g < NCH; g++) begin : ch
            logic rise, clr;
            assign rise = raw[g] && !req_prev_r[g];
            // clear write, exclude converter and receive
            assign sw_clr[g] = wr_acc && paddr_in == vim_pkg::ADDR_HIGH_STATUS &&
                               clr_code < 8'(NCH) && clr_idx == 4'(g) && g != vim_pkg::CH_RX &&
                               !(g == vim_pkg::CH_T2AD && src_sel);
            always_comb begin
                clr = acc_clr[g] || sw_clr[g];
                if (g == vim_pkg::CH_EXT0) begin
                    clr = clr || (lvl_s2_r != lvl_prev_r);
                end else if (g == vim_pkg::CH_T2AD) begin
                    // source change clears; converter cleared by result read
                    clr = src_sel ? (converter_result_read_in || src_sel != src_sel_prev_r ||
                                     acc_clr[g])
                                  : (clr || src_sel != src_sel_prev_r);
                end else if (g == vim_pkg::CH_RX) begin
                    clr = receive_buffer_read_in || acc_clr[g];
                end
            end
            // set wins over clear
            always_ff @(posedge clk_in) begin
                if (rst_in) begin
                    latch_r[g] <= 1'b0;
                end else if (rise) begin
                    latch_r[g] <= 1'b1;
                end else if (clr) begin
                    latch_r[g] <= 1'b0;
                end
            end
            assign pend[g] = ((g == vim_pkg::CH_EXT0 && lvl_s2_r) ? raw[g] : latch_r[g])
                             && irq_en[g];
        end
    endgenerate
    // fixed priority, lowest index wins; no compare against service
    always_comb begin
        win_idx = 4'h0;
        win_any = 1'b0;
        for (int i = NCH - 1; i >= 0; i--) begin
            if (pend[i]) begin
                win_idx = 4'(i);
                win_any = 1'b1;
            end
        end
    end
    // non maskable sources are edge latched and outrank all channels
    logic [2:0] nm_rise;
    assign nm_rise = nm_s2_r & ~nm_prev_r;
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            nm_latch_r <= '0;
        end else begin
            for (int i = 0; i < 3; i++) begin
                if (nm_rise[i]) begin
                    nm_latch_r[i] <= 1'b1;
                end else if (ack_in && irq_out && sel_nm_r && vector_out ==
                             vim_pkg::VEC_SWI + 8'(i) * vim_pkg::VEC_STEP) begin
                    nm_latch_r[i] <= 1'b0;
                end
            end
        end
    end

    // ============================================================
    // service sequencer
    vim_pkg::svc_state_t st_r;
    logic [5:0] cyc_r;
    logic [2:0] par_idx_r;
    logic [7:0] cnt_r, dstl_r, dsth_r, srcl_r, srch_r, mode_r;
    logic byte1_r;
    logic [15:0] src_w, dst_w, src_nxt, dst_nxt, step;
    logic two_byte;
    assign src_w = {srch_r, srcl_r};
    assign dst_w = {dsth_r, dstl_r};
    assign two_byte = mode_r[vim_pkg::MODE_LEN_BIT];
    assign step = two_byte ? 16'h0002 : 16'h0001;
    // address update per mode, full 16 bit wrap
    always_comb begin
        src_nxt = src_w;
        dst_nxt = dst_w;
        case (mode_r[1:0])
            vim_pkg::UPD_DST_INC: dst_nxt = dst_w + step;
            vim_pkg::UPD_SRC_INC: src_nxt = src_w + step;
            vim_pkg::UPD_SRC_DEC: src_nxt = src_w - step;
            default: ;
        endcase
    end
    logic [7:0] par_base;
    assign par_base = sel_vec_r;
    assign acc_clr = (ack_in && irq_out && !sel_nm_r) ? (NCH'(1) << sel_idx_r) : '0;
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            st_r <= vim_pkg::S_IDLE;
            {irq_out, sel_nm_r, sel_dma_r, entry_busy_out, clear_global_enable_out} <= '0;
            {mem_req_out, mem_we_out, byte1_r, cyc_r, par_idx_r, sel_idx_r} <= '0;
            {vector_out, sel_vec_r, mem_wdata_out, mem_addr_out} <= '0;
            {cnt_r, dstl_r, dsth_r, srcl_r, srch_r, mode_r} <= '0;
        end else begin
            clear_global_enable_out <= 1'b0;
            cyc_r <= (st_r == vim_pkg::S_IDLE) ? 6'd0 : cyc_r + 6'd1;
            case (st_r)
                vim_pkg::S_IDLE: begin
                    entry_busy_out <= 1'b0;
                    if (irq_out && ack_in) begin
                        irq_out <= 1'b0;
                        clear_global_enable_out <= 1'b1;
                        entry_busy_out <= 1'b1;
                        // dma enabled channel goes to dma
                        if (sel_dma_r) begin
                            st_r <= vim_pkg::S_RD_PAR;
                            par_idx_r <= 3'd1;
                            mem_req_out <= 1'b1;
                            mem_we_out <= 1'b0;
                            mem_addr_out <= vim_pkg::PARAM_BASE + {8'h00, par_base} + 16'd1;
                        end else begin
                            st_r <= vim_pkg::S_ENTRY;
                        end
                    end else if (nm_latch_r != 3'b000) begin
                        irq_out <= 1'b1;
                        sel_nm_r <= 1'b1;
                        sel_dma_r <= 1'b0;
                        vector_out <= nm_latch_r[0] ? vim_pkg::VEC_SWI :
                                      nm_latch_r[1] ? vim_pkg::VEC_NMI : vim_pkg::VEC_WD;
                    end else if (win_any && global_irq_enable_in) begin
                        irq_out <= 1'b1;
                        sel_nm_r <= 1'b0;
                        sel_idx_r <= win_idx;
                        sel_dma_r <= dma_en[win_idx];
                        vector_out <= vim_pkg::VEC_FIRST + 8'(win_idx) * vim_pkg::VEC_STEP;
                        sel_vec_r <= vim_pkg::VEC_FIRST + 8'(win_idx) * vim_pkg::VEC_STEP;
                    end else begin
                        irq_out <= 1'b0;
                    end
                end
                // entry window of 20 states; core pushes pc and af
                vim_pkg::S_ENTRY: begin
                    if (cyc_r == 6'(vim_pkg::ENTRY_STATES - 2)) begin
                        st_r <= vim_pkg::S_IDLE;
                    end
                end
                vim_pkg::S_RD_PAR: begin
                    if (mem_ack_in) begin
                        case (par_idx_r)
                            3'd1: dstl_r <= mem_rdata_in;
                            3'd2: dsth_r <= mem_rdata_in;
                            3'd3: srcl_r <= mem_rdata_in;
                            3'd4: srch_r <= mem_rdata_in;
                            default: mode_r <= mem_rdata_in;
                        endcase
                        if (par_idx_r == 3'd5) begin
                            st_r <= vim_pkg::S_RD_SRC;
                            byte1_r <= 1'b0;
                            mem_addr_out <= src_w;
                        end else begin
                            par_idx_r <= par_idx_r + 3'd1;
                            mem_addr_out <= mem_addr_out + 16'd1;
                        end
                    end
                end
                // copy source then source plus one
                vim_pkg::S_RD_SRC: begin
                    if (mem_ack_in) begin
                        st_r <= vim_pkg::S_WR_DST;
                        mem_we_out <= 1'b1;
                        mem_wdata_out <= mem_rdata_in;
                        mem_addr_out <= byte1_r ? dst_w + 16'd1 : dst_w;
                    end
                end
                vim_pkg::S_WR_DST: begin
                    if (mem_ack_in) begin
                        if (two_byte && !byte1_r) begin
                            byte1_r <= 1'b1;
                            st_r <= vim_pkg::S_RD_SRC;
                            mem_we_out <= 1'b0;
                            mem_addr_out <= src_w + 16'd1;
                        end else begin
                            // write back updated addresses, high source first
                            st_r <= vim_pkg::S_WR_PAR;
                            par_idx_r <= 3'd4;
                            mem_wdata_out <= src_nxt[15:8];
                            mem_addr_out <= vim_pkg::PARAM_BASE + {8'h00, par_base} + 16'd4;
                        end
                    end
                end
                vim_pkg::S_WR_PAR: begin
                    if (mem_ack_in) begin
                        if (par_idx_r == 3'd1) begin
                            st_r <= vim_pkg::S_RD_CNT;
                            mem_we_out <= 1'b0;
                            mem_addr_out <= vim_pkg::PARAM_BASE + {8'h00, par_base};
                        end else begin
                            par_idx_r <= par_idx_r - 3'd1;
                            mem_addr_out <= mem_addr_out - 16'd1;
                            case (par_idx_r)
                                3'd4: mem_wdata_out <= src_nxt[7:0];
                                3'd3: mem_wdata_out <= dst_nxt[15:8];
                                default: mem_wdata_out <= dst_nxt[7:0];
                            endcase
                        end
                    end
                end
                vim_pkg::S_RD_CNT: begin
                    if (mem_ack_in) begin
                        cnt_r <= mem_rdata_in - 8'd1;
                        st_r <= vim_pkg::S_WR_CNT;
                        mem_we_out <= 1'b1;
                        mem_wdata_out <= mem_rdata_in - 8'd1;
                    end
                end
                vim_pkg::S_WR_CNT: begin
                    if (mem_ack_in) begin
                        mem_req_out <= 1'b0;
                        mem_we_out <= 1'b0;
                        // zero count continues into normal entry
                        st_r <= (cnt_r == 8'h00) ? vim_pkg::S_ENTRY : vim_pkg::S_PAD;
                        cyc_r <= 6'd0;
                    end
                end
                // pad 27 cycles after the count write; no core registers touched
                vim_pkg::S_PAD: begin
                    if (cyc_r >= 6'(vim_pkg::DMA_STATES - vim_pkg::ENTRY_STATES)) begin
                        st_r <= vim_pkg::S_IDLE;
                    end
                end
                default: st_r <= vim_pkg::S_IDLE;
            endcase
        end
    end

    // ============================================================
    // apb read path; single wait-free access
    logic [7:0] rd_byte;
    always_comb begin
        rd_byte = 8'h00;
        if (paddr_in == vim_pkg::ADDR_LOW_STATUS) begin
            rd_byte = {1'b0, latch_r[0], latch_r[1], latch_r[2], 4'h0};
        end else if (paddr_in == vim_pkg::ADDR_HIGH_STATUS) begin
            for (int i = 0; i < 8; i++) begin
                rd_byte[7 - i] = latch_r[vim_pkg::CH_T2AD + i];
            end
        end else if (paddr_in == vim_pkg::ADDR_IRQ_EN) begin
            rd_byte = irq_en_r;
        end else if (paddr_in == vim_pkg::ADDR_IRQ_DMA_EN) begin
            rd_byte = irq_dma_en_r;
        end else if (paddr_in == vim_pkg::ADDR_DMA_EN) begin
            rd_byte = dma_en_r;
        end
    end
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            pready_out <= 1'b0;
            prdata_out <= 32'h0000_0000;
            pslverr_out <= 1'b0;
        end else begin
            pready_out <= psel_in && !penable_in;
            prdata_out <= {24'h000000, rd_byte};
            pslverr_out <= psel_in && !penable_in && !(paddr_in == vim_pkg::ADDR_LOW_STATUS
                || paddr_in == vim_pkg::ADDR_HIGH_STATUS || paddr_in == vim_pkg::ADDR_IRQ_EN
                || paddr_in == vim_pkg::ADDR_IRQ_DMA_EN || paddr_in == vim_pkg::ADDR_DMA_EN);
        end
    end
endmodule : vectored_irq_and_micro_dma

//--- test/vim_properties.sv
// port assertions for the interrupt and micro dma block
`timescale 1ns/10ps
module vim_properties (
    input logic clk_in,
    input logic rst_in,
    input logic psel_in,
    input logic penable_in,
    input logic [15:0] paddr_in,
    input logic pready_out,
    input logic pslverr_out,
    input logic global_irq_enable_in,
    input logic irq_out,
    input logic [7:0] vector_out,
    input logic ack_in,
    input logic clear_global_enable_out,
    input logic mem_req_out,
    input logic [15:0] mem_addr_out,
    input logic mem_ack_in
);
    // ============================================================
    // handshakes
    default clocking @(posedge clk_in); endclocking
    default disable iff (rst_in);
    sequence setup_s; psel_in && !penable_in; endsequence
    sequence accept_s; irq_out && ack_in; endsequence
    wire mapped = paddr_in inside {16'hFFC2, 16'hFFC3, 16'hFFE6, 16'hFFE7, 16'hFFE8};
    apb_ready_a: assert property (setup_s |=> pready_out)
        else $error("ready missing");
    ready_pulse_a: assert property (pready_out |=> !pready_out)
        else $error("ready too long");
    unmapped_err_a: assert property (pready_out |-> pslverr_out == !mapped)
        else $error("wrong error answer");
    accept_clear_a: assert property (accept_s |=> clear_global_enable_out && !irq_out)
        else $error("accept not honoured");
    clear_pulse_a: assert property (clear_global_enable_out |=> !clear_global_enable_out)
        else $error("clear pulse too long");
    irq_hold_a: assert property (irq_out && !ack_in |=> irq_out)
        else $error("request dropped");
    // maskable vectors lie above the watchdog one
    mask_gate_a: assert property ($rose(irq_out) && vector_out > 8'h20
        |-> $past(global_irq_enable_in)) else $error("masked request raised");
    mem_hold_a: assert property (mem_req_out && !mem_ack_in |=> $stable(mem_addr_out))
        else $error("address moved");
endmodule : vim_properties
bind vectored_irq_and_micro_dma vim_properties u_vim_properties (.*);

//--- test/dma_memory_model.sv
// byte memory serving the dma master, prompt or with two wait cycles
`timescale 1ns/10ps
module dma_memory_model (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic slow_in,
    input wire logic mem_req_in,
    input wire logic mem_we_in,
    input wire logic [15:0] mem_addr_in,
    input wire logic [7:0] mem_wdata_in,
    output logic [7:0] mem_rdata_out,
    output logic mem_ack_out
);
    logic [7:0] ram [0:65535];
    logic [1:0] wait_r;
    // read data valid only with ack, toggling otherwise so stale values never match
    always @(posedge clk_in) begin
        if (rst_in) begin
            mem_ack_out <= 1'b0;
            wait_r <= 2'h0;
            mem_rdata_out <= 8'h5A;
        end else if (mem_req_in && !mem_ack_out && wait_r == (slow_in ? 2'h2 : 2'h0)) begin
            mem_ack_out <= 1'b1;
            wait_r <= 2'h0;
            mem_rdata_out <= ram[mem_addr_in];
            if (mem_we_in) ram[mem_addr_in] <= mem_wdata_in;
        end else begin
            mem_ack_out <= 1'b0;
            wait_r <= (mem_req_in && !mem_ack_out) ? wait_r + 2'h1 : 2'h0;
            mem_rdata_out <= ~mem_rdata_out;
        end
    end
endmodule : dma_memory_model

//--- test/vectored_irq_and_micro_dma_tb.sv
// self-checking bench for the interrupt and micro dma block
`timescale 1ns/10ps
module vectored_irq_and_micro_dma_tb;
    logic clk_in = 0, rst_in = 1, psel_in = 0, penable_in = 0, pwrite_in = 0, ack_in = 0;
    logic global_irq_enable_in = 0, slow = 0, er;
    logic [15:0] paddr_in = 0, mem_addr_out, src, dst;
    logic [31:0] pwdata_in = 0, prdata_out, rd;
    logic [13:0] req_in = 0;
    logic [2:0] nm = 0;
    logic [7:0] vector_out, mem_wdata_out, mem_rdata_in, b0, b1, md, p [6];
    logic pready_out, pslverr_out, irq_out, entry_busy_out, clear_global_enable_out;
    logic mem_req_out, mem_we_out, mem_ack_in;
    int errors = 0, checked = 0, seed = 19325, n;
    vectored_irq_and_micro_dma u_vectored_irq_and_micro_dma (.*, .converter_done_request_in(1'b0),
        .ext0_level_mode_in(1'b0), .converter_result_read_in(1'b0), .receive_buffer_read_in(1'b0),
        .software_trap_in(nm[0]), .nmi_in(nm[1]), .watchdog_request_in(nm[2]));
    dma_memory_model u_dma_memory_model (.clk_in(clk_in), .rst_in(rst_in), .slow_in(slow),
        .mem_req_in(mem_req_out), .mem_we_in(mem_we_out), .mem_addr_in(mem_addr_out),
        .mem_wdata_in(mem_wdata_out), .mem_rdata_out(mem_rdata_in), .mem_ack_out(mem_ack_in));
    initial forever #25 clk_in = ~clk_in;
    // ============================================================
    // shared tasks
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        checked++;
        if (s !== e) begin
            errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [15:0] a, input logic [7:0] d);
        n = 0;
        @(posedge clk_in);
        psel_in <= 1;
        pwrite_in <= w;
        paddr_in <= a;
        pwdata_in <= {24'h000000, d};
        @(posedge clk_in);
        penable_in <= 1;
        do @(posedge clk_in); while (pready_out !== 1'b1 && ++n < 20);
        chk(pready_out, 1);
        rd = prdata_out;
        er = pslverr_out;
        psel_in <= 0;
        penable_in <= 0;
    endtask : apb
    task automatic take(input logic [7:0] v);
        n = 0;
        while (irq_out !== 1'b1 && n++ < 60) @(posedge clk_in);
        chk({irq_out, vector_out}, {1'b1, v});
        ack_in <= 1;
        @(posedge clk_in);
        ack_in <= 0;
        global_irq_enable_in <= 0;
        @(posedge clk_in);
        chk(clear_global_enable_out, 1);
    endtask : take
    function automatic logic [15:0] step(input logic [7:0] m, input logic s);
        logic [15:0] l;
        l = m[2] ? 16'h0002 : 16'h0001;
        if (!s) return (m[1:0] == 2'b01) ? l : 16'h0000;
        return (m[1:0] == 2'b10) ? l : (m[1:0] == 2'b11) ? -l : 16'h0000;
    endfunction : step
    function automatic logic [7:0] mb(input logic [15:0] a);
        return u_dma_memory_model.ram[a];
    endfunction : mb
    // timer0 channel, parameter block at FF30H
    task automatic dma(input logic [7:0] m, input logic [7:0] c);
        src = {8'h80, 8'($random(seed))};
        dst = {8'h90, 8'($random(seed))};
        b0 = 8'($random(seed));
        b1 = 8'($random(seed));
        u_dma_memory_model.ram[src] = b0;
        u_dma_memory_model.ram[16'(src + 1)] = b1;
        p = '{c, dst[7:0], dst[15:8], src[7:0], src[15:8], m};
        for (int i = 0; i < 6; i++) u_dma_memory_model.ram[16'hFF30 + i] = p[i];
        slow <= m[0];
        global_irq_enable_in <= 1;
        req_in[1] <= 1;
        take(8'h30);
        req_in[1] <= 0;
        @(posedge clk_in);
        while (entry_busy_out === 1'b1 && n++ < 400) @(posedge clk_in);
        chk(entry_busy_out, 0);
        chk(mb(dst), b0);
        if (m[2]) chk(mb(16'(dst + 1)), b1);
        chk({mb(16'hFF32), mb(16'hFF31)}, 16'(dst + step(m, 0)));
        chk({mb(16'hFF34), mb(16'hFF33)}, 16'(src + step(m, 1)));
        chk(mb(16'hFF30), 8'(c - 1));
    endtask : dma
    task automatic stop_test();
        if (errors == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : stop_test
    // ============================================================
    // scenarios
    initial begin
        repeat (10) @(posedge clk_in);
        rst_in <= 0;
        for (int i = 0; i < 3; i++) begin
            apb(0, 16'(16'hFFE6 + i), 0);
            chk(rd, 0);
            md = 8'($random(seed));
            apb(1, 16'(16'hFFE6 + i), md);
            apb(0, 16'(16'hFFE6 + i), 0);
            chk(rd, {24'h000000, i == 1 ? {1'b0, md[6:0]} : md});
        end
        apb(0, 16'hFFD0, 0);
        chk(er, 1);
        apb(1, 16'hFFE8, 0);
        apb(1, 16'hFFE7, 8'h07);
        global_irq_enable_in <= 1;
        req_in[1:0] <= 2'b11;
        take(8'h28);
        apb(0, 16'hFFC2, 0);
        chk(rd[6:4], 3'b010);
        global_irq_enable_in <= 1;
        take(8'h30);
        req_in[2] <= 1;
        repeat (10) @(posedge clk_in);
        chk(irq_out, 0);
        apb(0, 16'hFFC2, 0);
        chk(rd[4], 1);
        apb(1, 16'hFFC3, 8'h07);
        apb(0, 16'hFFC2, 0);
        chk(rd[4], 0);
        global_irq_enable_in <= 1;
        repeat (10) @(posedge clk_in);
        chk(irq_out, 0);
        global_irq_enable_in <= 0;
        req_in <= 0;
        for (int i = 0; i < 3; i++) begin
            @(posedge clk_in);
            nm[i] <= 1;
            take(8'(8'h10 + i * 8));
            nm <= 0;
        end
        apb(1, 16'hFFE6, 8'h01);
        global_irq_enable_in <= 1;
        req_in[10] <= 1;
        take(8'h78);
        req_in <= 0;
        apb(1, 16'hFFE7, 8'h22);
        for (int i = 0; i < 8; i++) dma({5'($random(seed)), 3'(i)}, 8'h02);
        dma(8'h05, 8'h01);
        stop_test();
    end
    initial begin
        repeat (30000) @(posedge clk_in);
        errors++;
        stop_test();
    end
endmodule : vectored_irq_and_micro_dma_tb
